/* rtl/tmr_pkg.sv */
/*
 Constants for the pulse-width timer block: register offsets, control field
 positions, reset values, mode and option codes.
 Assumes a single 20 MHz clock and a plain strobe register port.
*/
package tmr_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL0   = 4'h0;
   localparam logic [3:0] ADDR_CNT0    = 4'h1;
   localparam logic [3:0] ADDR_CTRL1   = 4'h2;
   localparam logic [3:0] ADDR_CNT1LO  = 4'h3;
   localparam logic [3:0] ADDR_CNT1HI  = 4'h4;
   localparam logic [3:0] ADDR_INTCTL  = 4'h5;
   localparam logic [3:0] ADDR_PORTA   = 4'h6;
   // ----------------------------------------------------------------
   // Control byte fields
   // ----------------------------------------------------------------
   localparam int MODE_HI    = 7;
   localparam int MODE_LO    = 6;
   localparam int CLKSRC_BIT = 5;
   localparam int RUN_BIT    = 4;
   localparam int EDGE_BIT   = 3;
   localparam int PSC_HI     = 2;
   // Interrupt control fields
   localparam int IE0_BIT = 0;
   localparam int IE1_BIT = 1;
   localparam int IF0_BIT = 2;
   localparam int IF1_BIT = 3;
   // Port A: direction bit three (1 = input), data bit three
   localparam int PA_DIR_BIT  = 0;
   localparam int PA_DATA_BIT = 1;
   // ----------------------------------------------------------------
   // Mode codes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_EVENT = 2'h1;
   localparam logic [1:0] MODE_TIMER = 2'h2;
   localparam logic [1:0] MODE_PWM   = 2'h3;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [1:0] PA_RST     = 2'h1;
   localparam logic [1:0] SUBDIV_LAST = 2'h3;
endpackage : tmr_pkg

/* rtl/pulse_width_timer.sv */
/*
 Two timer/event counters (8-bit with prescaler, 16-bit with sub clock or
 system clock / 4), pulse width measurement, frequency divider output,
 shared input noise filter.
 Assumes sub clock ticks arrive as a level from another domain; pins are
 asynchronous and are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
module pulse_width_timer #(
   parameter bit PFD_FROM_T1   = 1'b0,
   parameter bit PFD_ENABLE    = 1'b1,
   parameter bit FILTER_ENABLE = 1'b1,
   parameter int NUM_EXT_INT   = 3
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   // Register port
   input  wire logic [3:0]             regAddr,
   input  wire logic [7:0]             regWrData,
   input  wire logic                   regWrStb,
   input  wire logic                   regRdStb,
   output var  logic [7:0]             regRdData,
   // Pins
   input  wire logic                   timer0Pin,
   input  wire logic                   timer1Pin,
   input  wire logic                   subClockLvl,
   input  wire logic [NUM_EXT_INT-1:0] extIntPin,
   input  wire logic                   pullHighSel,
   output var  logic [NUM_EXT_INT-1:0] extIntFiltered,
   output var  logic                   pullHighEn,
   output var  logic                   paBit3Out,
   output var  logic                   paBit3Oe,
   // Events
   output var  logic                   timerIrq,
   output var  logic                   wakeUp
);
   // ----------------------------------------------------------------
   // Synchronisers and shared filter
   // ----------------------------------------------------------------
   localparam int NIN = NUM_EXT_INT + 3;
   logic [NIN-1:0] syncA_reg;
   logic [NIN-1:0] syncB_reg;
   logic [NIN-1:0] filt_reg;
   logic [NIN-1:0] filt_next;
   logic [NIN-1:0] syncC_reg;
   logic [NIN-1:0] clean;
   always_ff @(posedge clk) begin
      syncA_reg <= {extIntPin, subClockLvl, timer1Pin, timer0Pin};
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      filt_reg  <= sys_rst ? '0 : filt_next;
   end
   // Filter passes a level only after it held two samples; rejects spikes
   always_comb begin
      for (int i = 0; i < NIN; i++) begin
         filt_next[i] = (syncB_reg[i] == syncC_reg[i]) ? syncB_reg[i] : filt_reg[i];
      end
   end
   assign clean = FILTER_ENABLE ? filt_reg : syncB_reg;
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_reg [2];
   logic [7:0]  ctrl_next [2];
   logic [15:0] cnt_reg [2];
   logic [15:0] cnt_next [2];
   logic [15:0] pre_reg [2];
   logic [15:0] pre_next [2];
   logic [7:0]  loBuf_reg, loBuf_next, rdLatch_reg, rdLatch_next;
   logic [3:0]  intc_reg, intc_next;
   logic [1:0]  pa_reg, pa_next;
   logic [NIN-1:0] prev_reg;
   logic [1:0]  active_reg, active_next;
   logic [6:0]  psc_reg, psc_next;
   logic [1:0]  sub4_reg, sub4_next;
   logic        pfd_reg, pfd_next;
   logic [7:0]  rd_next;
   logic [1:0]  tick, ovf, pinRise, pinFall;
   logic        subTick, inhibit;

   function automatic logic [1:0] modeOf(input logic [7:0] c);
      modeOf = c[tmr_pkg::MODE_HI:tmr_pkg::MODE_LO];
   endfunction

   // ----------------------------------------------------------------
   // Clock sources
   // ----------------------------------------------------------------
   assign subTick = clean[2] & ~prev_reg[2];
   assign inhibit = (regRdStb & (regAddr == tmr_pkg::ADDR_CNT0 ||
                    regAddr == tmr_pkg::ADDR_CNT1HI)) |
                    (regWrStb & (regAddr == tmr_pkg::ADDR_CNT0 ||
                    regAddr == tmr_pkg::ADDR_CNT1HI));
   always_comb begin
      logic [7:0] c0;
      c0 = ctrl_reg[0];
      psc_next  = psc_reg + 7'h01;
      sub4_next = sub4_reg + 2'h1;
      pinRise   = {clean[1] & ~prev_reg[1], clean[0] & ~prev_reg[0]};
      pinFall   = {~clean[1] & prev_reg[1], ~clean[0] & prev_reg[0]};
      // Prescaler: rate r divides by 2^r, r = 0 is undivided
      tick[0] = (c0[tmr_pkg::PSC_HI:0] == 3'h0) ? 1'b1 :
                (psc_reg & ((7'h01 << (c0[tmr_pkg::PSC_HI:0] - 3'h1)) - 7'h01)) == 7'h00
                && psc_reg[c0[tmr_pkg::PSC_HI:0] - 3'h1];
      tick[1] = ctrl_reg[1][tmr_pkg::CLKSRC_BIT] ? subTick
              : (sub4_reg == tmr_pkg::SUBDIV_LAST);
   end

   // ----------------------------------------------------------------
   // Counters, control, preload, pulse measurement
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] top;
      logic        startEdge, stopEdge, inc;
      top          = 16'h00FF;
      startEdge    = 1'b0;
      stopEdge     = 1'b0;
      inc          = 1'b0;
      for (int n = 0; n < 2; n++) begin
         ctrl_next[n] = ctrl_reg[n];
         cnt_next[n]  = cnt_reg[n];
         pre_next[n]  = pre_reg[n];
      end
      active_next  = active_reg;
      loBuf_next   = loBuf_reg;
      rdLatch_next = rdLatch_reg;
      intc_next    = intc_reg;
      pa_next      = pa_reg;
      ovf          = 2'b00;
      for (int n = 0; n < 2; n++) begin
         top = (n == 0) ? 16'h00FF : 16'hFFFF;
         startEdge = ctrl_reg[n][tmr_pkg::EDGE_BIT] ? pinRise[n] : pinFall[n];
         stopEdge  = ctrl_reg[n][tmr_pkg::EDGE_BIT] ? pinFall[n] : pinRise[n];
         inc = 1'b0;
         if (ctrl_reg[n][tmr_pkg::RUN_BIT] && !inhibit) begin
            case (modeOf(ctrl_reg[n]))
               tmr_pkg::MODE_TIMER: inc = tick[n];
               tmr_pkg::MODE_EVENT: inc = stopEdge;
               tmr_pkg::MODE_PWM: begin
                  // Edges only, levels never start a count
                  if (!active_reg[n] && startEdge) begin
                     active_next[n] = 1'b1;
                  end else if (active_reg[n] && stopEdge) begin
                     active_next[n] = 1'b0;
                     ctrl_next[n][tmr_pkg::RUN_BIT] = 1'b0;
                  end else begin
                     inc = active_reg[n] & tick[n];
                  end
               end
               default: inc = 1'b0;
            endcase
         end
         if (!ctrl_reg[n][tmr_pkg::RUN_BIT]) begin
            active_next[n] = 1'b0;
         end
         if (inc) begin
            if (cnt_reg[n] == top) begin
               cnt_next[n] = pre_reg[n];
               ovf[n] = 1'b1;
            end else begin
               cnt_next[n] = cnt_reg[n] + 16'h0001;
            end
         end
      end
      // Register writes
      if (regWrStb) begin
         case (regAddr)
            tmr_pkg::ADDR_CTRL0: ctrl_next[0] = regWrData;
            tmr_pkg::ADDR_CTRL1: ctrl_next[1] = regWrData;
            tmr_pkg::ADDR_CNT0: begin
               pre_next[0] = {8'h00, regWrData};
               if (!ctrl_reg[0][tmr_pkg::RUN_BIT]) cnt_next[0] = {8'h00, regWrData};
            end
            tmr_pkg::ADDR_CNT1LO: loBuf_next = regWrData;
            tmr_pkg::ADDR_CNT1HI: begin
               pre_next[1] = {regWrData, loBuf_reg};
               if (!ctrl_reg[1][tmr_pkg::RUN_BIT]) cnt_next[1] = {regWrData, loBuf_reg};
            end
            tmr_pkg::ADDR_INTCTL: intc_next = regWrData[3:0];
            tmr_pkg::ADDR_PORTA:  pa_next = regWrData[1:0];
            default: ;
         endcase
      end
      if (regRdStb && regAddr == tmr_pkg::ADDR_CNT1HI) begin
         rdLatch_next = cnt_reg[1][7:0];
      end
      // Hardware set wins over a software clear
      if (ovf[0]) intc_next[tmr_pkg::IF0_BIT] = 1'b1;
      if (ovf[1]) intc_next[tmr_pkg::IF1_BIT] = 1'b1;
   end

   // ----------------------------------------------------------------
   // Read mux and divider output
   // ----------------------------------------------------------------
   always_comb begin
      rd_next = 8'h00;
      if (regRdStb) begin
         case (regAddr)
            tmr_pkg::ADDR_CTRL0:  rd_next = ctrl_reg[0];
            tmr_pkg::ADDR_CTRL1:  rd_next = ctrl_reg[1];
            tmr_pkg::ADDR_CNT0:   rd_next = cnt_reg[0][7:0];
            tmr_pkg::ADDR_CNT1LO: rd_next = rdLatch_reg;
            tmr_pkg::ADDR_CNT1HI: rd_next = cnt_reg[1][15:8];
            tmr_pkg::ADDR_INTCTL: rd_next = {4'h0, intc_reg};
            tmr_pkg::ADDR_PORTA:  rd_next = {6'h00, pa_reg};
            default:              rd_next = 8'h00;
         endcase
      end
      pfd_next = pfd_reg ^ (PFD_FROM_T1 ? ovf[1] : ovf[0]);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int n = 0; n < 2; n++) begin
            ctrl_reg[n] <= tmr_pkg::CTRL_RST;
            cnt_reg[n]  <= 16'h0000;
            pre_reg[n]  <= 16'h0000;
         end
         prev_reg    <= '0;
         active_reg  <= 2'b00;
         psc_reg     <= 7'h00;
         sub4_reg    <= 2'h0;
         loBuf_reg   <= 8'h00;
         rdLatch_reg <= 8'h00;
         intc_reg    <= 4'h0;
         pa_reg      <= tmr_pkg::PA_RST;
         pfd_reg     <= 1'b0;
         regRdData   <= 8'h00;
         timerIrq    <= 1'b0;
         wakeUp      <= 1'b0;
         paBit3Out   <= 1'b0;
         paBit3Oe    <= 1'b0;
         pullHighEn  <= 1'b0;
         extIntFiltered <= '0;
      end else begin
         for (int n = 0; n < 2; n++) begin
            ctrl_reg[n] <= ctrl_next[n];
            cnt_reg[n]  <= cnt_next[n];
            pre_reg[n]  <= pre_next[n];
         end
         prev_reg    <= clean;
         active_reg  <= active_next;
         psc_reg     <= psc_next;
         sub4_reg    <= sub4_next;
         loBuf_reg   <= loBuf_next;
         rdLatch_reg <= rdLatch_next;
         intc_reg    <= intc_next;
         pa_reg      <= pa_next;
         pfd_reg     <= pfd_next;
         regRdData   <= rd_next;
         timerIrq    <= (ovf[0] & intc_reg[tmr_pkg::IE0_BIT]) |
                        (ovf[1] & intc_reg[tmr_pkg::IE1_BIT]);
         wakeUp      <= |ovf;
         // Divider gated by data bit, low when data bit zero
         paBit3Out   <= pa_reg[tmr_pkg::PA_DATA_BIT] & (PFD_ENABLE ? pfd_reg : 1'b1);
         paBit3Oe    <= ~pa_reg[tmr_pkg::PA_DIR_BIT];
         pullHighEn  <= pullHighSel;
         extIntFiltered <= clean[NIN-1:3];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_run_autoclear: assert property (@(posedge clk) disable iff (sys_rst)
      (active_reg[0] && ctrl_reg[0][tmr_pkg::RUN_BIT] && !inhibit &&
       modeOf(ctrl_reg[0]) == tmr_pkg::MODE_PWM &&
       (ctrl_reg[0][tmr_pkg::EDGE_BIT] ? pinFall[0] : pinRise[0]))
      |=> !ctrl_reg[0][tmr_pkg::RUN_BIT]) else $error("run not cleared");
   a_hold_stopped: assert property (@(posedge clk) disable iff (sys_rst)
      (!ctrl_reg[0][tmr_pkg::RUN_BIT] && !regWrStb) |=> $stable(cnt_reg[0]))
      else $error("stopped counter moved");
   a_flag_on_ovf: assert property (@(posedge clk) disable iff (sys_rst)
      ovf[0] |=> intc_reg[tmr_pkg::IF0_BIT]) else $error("flag not set");
   a_wake_follows: assert property (@(posedge clk) disable iff (sys_rst)
      (|ovf) |=> wakeUp) else $error("no wake");
   a_pfd_toggle: assert property (@(posedge clk) disable iff (sys_rst)
      ovf[PFD_FROM_T1] |=> pfd_reg != $past(pfd_reg)) else $error("no toggle");
   a_pin_low_off: assert property (@(posedge clk) disable iff (sys_rst)
      !pa_reg[tmr_pkg::PA_DATA_BIT] |=> !paBit3Out) else $error("pin not low");
   a_reload_pre: assert property (@(posedge clk) disable iff (sys_rst)
      (ovf[1] && !regWrStb) |=> cnt_reg[1] == $past(pre_reg[1])) else $error("bad reload");
   a_inhibit_cnt: assert property (@(posedge clk) disable iff (sys_rst)
      (regRdStb && regAddr == tmr_pkg::ADDR_CNT0) |=> $stable(cnt_reg[0]))
      else $error("count during read");
   c_pulse_done: cover property (@(posedge clk) active_reg[0] ##1 !active_reg[0]);
   c_ovf1: cover property (@(posedge clk) ovf[1]);
   c_pfd_high: cover property (@(posedge clk) paBit3Out);
endmodule : pulse_width_timer
`default_nettype wire

/* test/pulse_source.sv */
/*
 Partner model: external pulse and event source on the timer 0 input pin.
 Assumes the bench sets the idle level and asks for one pulse at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
   // Clock
   input  wire logic       clk,
   // Requests from the bench
   input  wire logic       idleLvl,
   input  wire logic       pulseReq,
   input  wire logic [7:0] pulseLen,
   // Pin
   output var  logic       pinLvl
);
   int left = 0;
   initial pinLvl = 1'b1;
   // -------------------------------------------------------------
   // Pulse generation
   // -------------------------------------------------------------
   // Pin moves 13 ns after each rising clock edge, away from the sampling edge
   // Drives a plain input pin, always at a defined level
   always @(posedge clk) begin
      #13;
      if (left > 0) begin
         left--;
      end else if (pulseReq) begin
         left = pulseLen;
      end
      pinLvl = (left > 0) ? !idleLvl : idleLvl;
   end
endmodule : pulse_source
`default_nettype wire

/* test/tb.sv */
/*
 Self-checking bench for the pulse-width timer: pulse measurement rows,
 event counting, timer overflow, interrupt, wake-up and divider pin.
 Assumes the register map and latencies of the timer package.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct {logic edgeSel; logic [2:0] rate; logic [7:0] width;} row_t;
   logic       clk = 0, sysRst = 1, wrStb = 0, rdStb = 0, pullSel = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wrData = 8'h00, rdData, rv, c0;
   logic       idleLvl = 1, pulseReq = 0, pin0;
   logic [7:0] pulseLen = 8'h00;
   logic [2:0] extFilt;
   logic       pullEn, paOut, paOe, irq, wake, clrCnt = 0, prevOut = 0;
   int         n_mismatch = 0, n_tests = 0, nWake = 0, nIrq = 0, nTog = 0;
   row_t rows[4] = '{'{1'b0, 3'h0, 8'h0A}, '{1'b1, 3'h0, 8'h20},
                     '{1'b0, 3'h1, 8'h14}, '{1'b1, 3'h2, 8'h28}};
   always #25 clk = ~clk;
   pulse_source src (.clk(clk), .idleLvl(idleLvl), .pulseReq(pulseReq),
                     .pulseLen(pulseLen), .pinLvl(pin0));
   pulse_width_timer dut (.clk(clk), .sys_rst(sysRst), .regAddr(addr),
      .regWrData(wrData), .regWrStb(wrStb), .regRdStb(rdStb), .regRdData(rdData),
      .timer0Pin(pin0), .timer1Pin(1'b0), .subClockLvl(1'b0), .extIntPin(3'h0),
      .pullHighSel(pullSel), .extIntFiltered(extFilt), .pullHighEn(pullEn),
      .paBit3Out(paOut), .paBit3Oe(paOe), .timerIrq(irq), .wakeUp(wake));
   // -------------------------------------------------------------
   // Event counters for overflow windows
   // -------------------------------------------------------------
   always @(posedge clk) begin
      if (clrCnt) begin
         nWake <= 0; nIrq <= 0; nTog <= 0;
      end else begin
         nWake <= nWake + int'(wake === 1'b1);
         nIrq  <= nIrq + int'(irq === 1'b1);
         nTog  <= nTog + int'(paOut !== prevOut);
      end
      prevOut <= paOut;
   end
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Input sync gives a small skew, so a window is accepted
   task automatic chkr(input int v, input int lo, input int hi);
      chk({15'h0, v >= lo && v <= hi}, 16'h1);
   endtask : chkr
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wrStb <= 1; addr <= a; wrData <= d;
      @(posedge clk);
      wrStb <= 0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      rdStb <= 1; addr <= a;
      @(posedge clk);
      rdStb <= 0;
      #1 d = rdData;
   endtask : rd
   task automatic pulse(input logic [7:0] len, input int gap);
      @(posedge clk);
      pulseLen <= len; pulseReq <= 1;
      @(posedge clk);
      pulseReq <= 0;
      repeat (int'(len) + gap) @(posedge clk);
   endtask : pulse
   task automatic window(input int n);
      @(posedge clk) clrCnt <= 1;
      @(posedge clk) clrCnt <= 0;
      repeat (n) @(posedge clk);
   endtask : window
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      sysRst <= 0;
      rd(tmr_pkg::ADDR_CTRL0, rv); chk(rv, tmr_pkg::CTRL_RST);
      rd(tmr_pkg::ADDR_PORTA, rv); chk(rv, {6'h00, tmr_pkg::PA_RST});
      chk({irq, wake, paOe}, 3'h0);
      rd(4'hF, rv); chk(rv, 8'h00);
      rd(tmr_pkg::ADDR_PORTA, rv); @(posedge clk); #1 chk(rdData, 8'h00);
      chk(extFilt, 3'h0);
      pullSel <= 1;
      repeat (3) @(posedge clk);
      chk(pullEn, 1'b1);
      // Pulse rows; mode written before the run bit, counter preset
      foreach (rows[i]) begin
         idleLvl <= !rows[i].edgeSel;
         c0 = {2'b11, 2'b00, rows[i].edgeSel, rows[i].rate};
         wr(tmr_pkg::ADDR_CTRL0, c0);
         wr(tmr_pkg::ADDR_CNT0, 8'h00);
         wr(tmr_pkg::ADDR_CTRL0, c0 | 8'h10);
         repeat (10) @(posedge clk);
         rd(tmr_pkg::ADDR_CNT0, rv); chk(rv, 8'h00);
         pulse(rows[i].width, 12);
         rd(tmr_pkg::ADDR_CTRL0, rv); chk(rv, c0);
         rd(tmr_pkg::ADDR_CNT0, rv);
         chkr(rv, (rows[i].width >> rows[i].rate) - 1,
              (rows[i].width >> rows[i].rate) + 1);
         c0 = rv;
         pulse(8'h08, 12);
         rd(tmr_pkg::ADDR_CNT0, rv); chk(rv, c0);
      end
      // Event counting on rising edges
      idleLvl <= 0;
      wr(tmr_pkg::ADDR_CTRL0, 8'h40);
      wr(tmr_pkg::ADDR_CNT0, 8'h00);
      wr(tmr_pkg::ADDR_CTRL0, 8'h50);
      repeat (5) pulse(8'h06, 8);
      rd(tmr_pkg::ADDR_CNT0, rv); chk(rv, 8'h05);
      rd(tmr_pkg::ADDR_CTRL0, rv); chk(rv, 8'h50);
      // Timer overflow every 16 cycles from preload F0
      wr(tmr_pkg::ADDR_INTCTL, 8'h00);
      wr(tmr_pkg::ADDR_PORTA, 8'h02);
      wr(tmr_pkg::ADDR_CTRL0, 8'h80);
      wr(tmr_pkg::ADDR_CNT0, 8'hF0);
      wr(tmr_pkg::ADDR_CTRL0, 8'h90);
      window(160);
      chkr(nWake, 9, 11);
      chk(nIrq, 16'h0);
      chkr(nTog, 9, 11);
      chk(paOe, 1'b1);
      rd(tmr_pkg::ADDR_INTCTL, rv); chk(rv[tmr_pkg::IF0_BIT], 1'b1);
      wr(tmr_pkg::ADDR_INTCTL, 8'h01);
      window(160);
      chkr(nIrq, 9, 11);
      rd(tmr_pkg::ADDR_CTRL0, rv); chk(rv, 8'h90);
      // Data bit low holds the divider pin low
      wr(tmr_pkg::ADDR_PORTA, 8'h00);
      window(40);
      chk({15'h0, paOut}, 16'h0);
      chk(16'(nTog), 16'h0);
      // Flag preset before sleep keeps wake from mattering to software
      wr(tmr_pkg::ADDR_INTCTL, 8'h04);
      rd(tmr_pkg::ADDR_INTCTL, rv); chk(rv, 8'h04);
      finish_test();
   end
endmodule : tb
`default_nettype wire
